// ===== core/osu_operand_stack.sv
`timescale 1ns/1ps
module osu_operand_stack import osu_pkg::*; #(
	parameter int MEM_BASE  = 0,
	parameter int MEM_WORDS = 1024
) (
	input  wire logic                   clk_i,
	input  wire logic                   srst_i,
	input  wire logic                   op_valid_i,
	input  wire osu_op_s                op_i,
	output logic                        op_ready_o,
	input  wire osu_bnd_s               bnd_i,
	input  wire logic                   viol_clr_i,
	output logic [OSU_WORD_W-1:0]       top_o,
	output logic [OSU_WORD_W-1:0]       second_o,
	output logic [OSU_WORD_W-1:0]       third_o,
	output logic [OSU_WORD_W-1:0]       result_o,
	output logic                        result_valid_o,
	output logic [OSU_DEPTH_W-1:0]      depth_o,
	output logic                        viol_o,
	output osu_mem_s                    mem_o,
	input  wire logic                   mem_ack_i,
	input  wire logic [OSU_WORD_W-1:0]  mem_rdata_i
);

	localparam logic [OSU_DEPTH_W-1:0] CAP      = OSU_DEPTH_W'(OSU_EXT_WORDS + 2 + MEM_WORDS);
	localparam logic [OSU_ADDR_W-1:0]  BASE     = OSU_ADDR_W'(MEM_BASE);
	localparam logic [OSU_ADDR_W-1:0]  ROOM_TOP = OSU_ADDR_W'(MEM_BASE + MEM_WORDS - OSU_GROUP_WORDS);

	if (MEM_WORDS % OSU_GROUP_WORDS != 0 || MEM_WORDS < OSU_GROUP_WORDS ||
		MEM_BASE + MEM_WORDS > 2**OSU_ADDR_W || OSU_EXT_WORDS + 2 + MEM_WORDS >= 2**OSU_DEPTH_W) begin : g_bad
		$error("operand stack memory window does not fit");
	end

	function automatic logic [OSU_WORD_W-1:0] osu_alu(osu_alu_e f, logic [OSU_WORD_W-1:0] l,
		logic [OSU_WORD_W-1:0] r);
		case (f)
			OSU_ADD: osu_alu = l + r;
			OSU_SUB: osu_alu = l - r;
			OSU_AND: osu_alu = l & r;
			OSU_OR:  osu_alu = l | r;
			OSU_XOR: osu_alu = l ^ r;
			default: osu_alu = l;
		endcase
	endfunction : osu_alu

	osu_op_s                                      fop_reg;
	logic                                         fop_vld_reg;
	logic [OSU_WORD_W-1:0]                        top_reg, top_next;
	logic [OSU_WORD_W-1:0]                        sec_reg, sec_next;
	logic [OSU_WORD_W-1:0]                        thr_reg;
	logic [OSU_WORD_W-1:0]                        res_reg;
	logic                                         res_vld_reg;
	logic [OSU_EXT_WORDS-1:0][OSU_WORD_W-1:0]     ext_reg, ext_next, ext_sel;
	logic [3:0]                                   ecnt_reg, ecnt_next;
	logic [OSU_DEPTH_W-1:0]                       depth_reg, depth_next;
	logic [OSU_DEPTH_W-1:0]                       upper_reg, lower_reg;
	logic [OSU_ADDR_W-1:0]                        mptr_reg;
	logic [1:0]                                   beat_reg;
	osu_st_e                                      st_reg;
	logic                                         viol_reg;

	wire osu_cmd_e               cmd       = fop_reg.cmd;
	wire logic [OSU_WORD_W-1:0]  op_data   = fop_reg.data;
	wire logic                   mem_room  = mptr_reg <= ROOM_TOP;
	wire logic                   mem_any   = mptr_reg != BASE;
	wire logic                   need_sp   = ecnt_reg >= OSU_SPILL_AT && mem_room;
	wire logic                   need_fl   = ecnt_reg < OSU_REFILL_BELOW && mem_any;
	// Spill and refill own the extension, so the op waits rather than racing the shifter
	wire logic                   exec      = fop_vld_reg && st_reg == OSU_IDLE && !need_sp && !need_fl;
	wire logic [OSU_DEPTH_W-1:0] need_n    = cmd == OSU_POP ? 16'h0001 :
		(cmd == OSU_POP2 || cmd == OSU_ARITH) ? 16'h0002 : 16'h0000;
	wire logic [OSU_DEPTH_W-1:0] drop_n    = (cmd == OSU_POP || cmd == OSU_ARITH) ? 16'h0001 :
		cmd == OSU_POP2 ? 16'h0002 : 16'h0000;
	wire logic [OSU_DEPTH_W-1:0] grow_n    = cmd == OSU_PUSH ? 16'h0001 : cmd == OSU_PUSH2 ? 16'h0002 : 16'h0000;
	wire logic                   under     = depth_reg < need_n ||
		(drop_n != 16'h0000 && depth_reg - drop_n < lower_reg);
	wire logic                   over      = grow_n != 16'h0000 && depth_reg + grow_n > upper_reg;
	wire logic                   viol_now  = exec && (under || over);
	wire logic                   ok        = exec && !viol_now;
	wire logic                   sp_ack    = st_reg == OSU_SPILL && mem_ack_i;
	wire logic                   fl_ack    = st_reg == OSU_FILL && mem_ack_i;
	wire logic                   hard_full = depth_reg >= 16'h0002;
	wire logic [OSU_WORD_W-1:0]  alu_res   = osu_alu(fop_reg.alu, sec_reg, top_reg);

	assign op_ready_o = !fop_vld_reg || exec;

	// Shifted images of the extension for each stack move
	always_comb begin
		ext_sel = ext_reg;
		if (ok) begin
			case (cmd)
				OSU_PUSH:  ext_sel = {ext_reg[OSU_EXT_WORDS-2:0], sec_reg};
				OSU_PUSH2: ext_sel = {ext_reg[OSU_EXT_WORDS-3:0], sec_reg, top_reg};
				OSU_POP,
				OSU_ARITH: ext_sel = {{OSU_WORD_W{1'b0}}, ext_reg[OSU_EXT_WORDS-1:1]};
				OSU_POP2:  ext_sel = {{(2*OSU_WORD_W){1'b0}}, ext_reg[OSU_EXT_WORDS-1:2]};
				default:   ext_sel = ext_reg;
			endcase
		end
	end

	// Refilled words land just below the deepest word still held
	for (genvar k = 0; k < OSU_EXT_WORDS; k++) begin : g_ext
		assign ext_next[k] = (fl_ack && ecnt_reg == 4'(k)) ? mem_rdata_i : ext_sel[k];
	end

	always_comb begin
		top_next   = top_reg;
		sec_next   = sec_reg;
		ecnt_next  = ecnt_reg;
		depth_next = depth_reg;
		if (ok) begin
			depth_next = depth_reg + grow_n - drop_n;
			case (cmd)
				OSU_PUSH: begin
					top_next  = op_data;
					sec_next  = top_reg;
					ecnt_next = ecnt_reg + {3'h0, hard_full};
				end
				OSU_PUSH2: begin
					top_next  = op_data;
					sec_next  = fop_reg.data2;
					ecnt_next = ecnt_reg + (hard_full ? 4'h2 : depth_reg[3:0]);
				end
				OSU_POP: begin
					top_next  = sec_reg;
					sec_next  = ext_reg[0];
					ecnt_next = ecnt_reg - {3'h0, ecnt_reg != 4'h0};
				end
				OSU_POP2: begin
					top_next  = ext_reg[0];
					sec_next  = ext_reg[1];
					ecnt_next = ecnt_reg - (ecnt_reg >= 4'h2 ? 4'h2 : ecnt_reg);
				end
				OSU_ARITH: begin
					top_next  = alu_res;
					sec_next  = ext_reg[0];
					ecnt_next = ecnt_reg - {3'h0, ecnt_reg != 4'h0};
				end
				default: begin
					top_next = top_reg;
				end
			endcase
		end else if (sp_ack) begin
			ecnt_next = ecnt_reg - 4'h1;
		end else if (fl_ack) begin
			ecnt_next = ecnt_reg + 4'h1;
		end
	end

	// Deepest word goes first, so a group occupies adjacent ascending addresses
	assign mem_o.req   = st_reg != OSU_IDLE;
	assign mem_o.we    = st_reg == OSU_SPILL;
	assign mem_o.addr  = st_reg == OSU_FILL ? mptr_reg - 16'h0001 : mptr_reg;
	assign mem_o.wdata = ext_reg[4'(ecnt_reg - 4'h1)];

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			fop_vld_reg <= 1'b0;
			fop_reg     <= '0;
		end else if (op_valid_i && op_ready_o) begin
			fop_vld_reg <= 1'b1;
			fop_reg     <= op_i;
		end else if (exec) begin
			fop_vld_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			top_reg   <= '0;
			sec_reg   <= '0;
			ext_reg   <= '0;
			ecnt_reg  <= 4'h0;
			depth_reg <= 16'h0000;
		end else begin
			top_reg   <= top_next;
			sec_reg   <= sec_next;
			ext_reg   <= ext_next;
			ecnt_reg  <= ecnt_next;
			depth_reg <= depth_next;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			thr_reg <= '0;
		end else if (ok && cmd == OSU_LOAD3) begin
			thr_reg <= op_data;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			res_reg     <= '0;
			res_vld_reg <= 1'b0;
		end else begin
			res_vld_reg <= ok && (cmd == OSU_POP || cmd == OSU_POP2 || cmd == OSU_ARITH);
			if (ok && (cmd == OSU_POP || cmd == OSU_POP2)) begin
				res_reg <= top_reg;
			end else if (ok && cmd == OSU_ARITH) begin
				res_reg <= alu_res;
			end
		end
	end

	// Upper bound is clamped to what the top two registers, the extension and memory window can really hold
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			upper_reg <= CAP;
			lower_reg <= OSU_LOWER_RST;
		end else if (bnd_i.load) begin
			upper_reg <= bnd_i.upper > CAP ? CAP : bnd_i.upper;
			lower_reg <= bnd_i.lower;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			viol_reg <= 1'b0;
		end else if (viol_now) begin
			viol_reg <= 1'b1;
		end else if (viol_clr_i) begin
			viol_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st_reg   <= OSU_IDLE;
			beat_reg <= 2'h0;
			mptr_reg <= BASE;
		end else begin
			case (st_reg)
				OSU_IDLE: begin
					beat_reg <= 2'h0;
					if (need_sp) begin
						st_reg <= OSU_SPILL;
					end else if (need_fl) begin
						st_reg <= OSU_FILL;
					end
				end
				OSU_SPILL, OSU_FILL: begin
					if (mem_ack_i) begin
						beat_reg <= beat_reg + 2'h1;
						mptr_reg <= st_reg == OSU_SPILL ? mptr_reg + 16'h0001 : mptr_reg - 16'h0001;
						if (beat_reg == OSU_LAST_BEAT) begin
							st_reg <= OSU_IDLE;
						end
					end
				end
				default: st_reg <= OSU_IDLE;
			endcase
		end
	end

	assign top_o          = top_reg;
	assign second_o       = sec_reg;
	assign third_o        = thr_reg;
	assign result_o       = res_reg;
	assign result_valid_o = res_vld_reg;
	assign depth_o        = depth_reg;
	assign viol_o         = viol_reg;

	property p_push_top;
		@(posedge clk_i) disable iff (srst_i) ok && cmd == OSU_PUSH |=> top_reg == $past(op_data) &&
			sec_reg == $past(top_reg) && depth_reg == $past(depth_reg) + 16'h0001;
	endproperty
	a_push_top: assert property (p_push_top) else $error("push did not move words deeper");

	property p_pop_order;
		@(posedge clk_i) disable iff (srst_i) ok && cmd == OSU_POP |=> top_reg == $past(sec_reg) &&
			result_valid_o && result_o == $past(top_reg);
	endproperty
	a_pop_order: assert property (p_pop_order) else $error("pop did not return most recent word");

	property p_pop2_depth;
		@(posedge clk_i) disable iff (srst_i) ok && cmd == OSU_POP2 |=> depth_reg == $past(depth_reg) - 16'h0002 &&
			top_reg == $past(ext_reg[0]);
	endproperty
	a_pop2_depth: assert property (p_pop2_depth) else $error("double step-up wrong");

	property p_arith;
		@(posedge clk_i) disable iff (srst_i) ok && cmd == OSU_ARITH && fop_reg.alu == OSU_SUB |=>
			top_reg == $past(sec_reg) - $past(top_reg) && depth_reg == $past(depth_reg) - 16'h0001;
	endproperty
	a_arith: assert property (p_arith) else $error("arithmetic operand order or result wrong");

	property p_underflow;
		@(posedge clk_i) disable iff (srst_i) exec && depth_reg < need_n |=> viol_o && $stable(depth_reg);
	endproperty
	a_underflow: assert property (p_underflow) else $error("underflow not flagged");

	property p_overflow;
		@(posedge clk_i) disable iff (srst_i) exec && grow_n != 16'h0000 && depth_reg + grow_n > upper_reg |=>
			viol_o && $stable(top_reg);
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow not flagged");

	property p_third;
		@(posedge clk_i) disable iff (srst_i) !(ok && cmd == OSU_LOAD3) |=> $stable(thr_reg);
	endproperty
	a_third: assert property (p_third) else $error("third register changed unbidden");

	property p_ext_cap;
		@(posedge clk_i) disable iff (srst_i) ecnt_reg <= 4'(OSU_EXT_WORDS);
	endproperty
	a_ext_cap: assert property (p_ext_cap) else $error("extension count past twelve");

	property p_group;
		@(posedge clk_i) disable iff (srst_i) st_reg == OSU_IDLE |-> mptr_reg[1:0] == BASE[1:0];
	endproperty
	a_group: assert property (p_group) else $error("memory pointer not on a group");

	property p_spill_addr;
		@(posedge clk_i) disable iff (srst_i) sp_ack && beat_reg != OSU_LAST_BEAT |=>
			mem_o.we && mem_o.addr == $past(mem_o.addr) + 16'h0001;
	endproperty
	a_spill_addr: assert property (p_spill_addr) else $error("spill addresses not sequential");

endmodule : osu_operand_stack

// ===== core/osu_pkg.sv
package osu_pkg;

	localparam int          OSU_WORD_W       = 32;
	localparam int          OSU_ADDR_W       = 16;
	localparam int          OSU_DEPTH_W      = 16;
	localparam int          OSU_EXT_WORDS    = 12;
	localparam int          OSU_GROUP_WORDS  = 4;
	localparam logic [3:0]  OSU_SPILL_AT     = 4'hb;
	localparam logic [3:0]  OSU_REFILL_BELOW = 4'h2;
	localparam logic [1:0]  OSU_LAST_BEAT    = 2'h3;
	localparam logic [15:0] OSU_LOWER_RST    = 16'h0000;

	typedef enum logic [2:0] {
		OSU_NOP,
		OSU_PUSH,
		OSU_PUSH2,
		OSU_POP,
		OSU_POP2,
		OSU_ARITH,
		OSU_LOAD3
	} osu_cmd_e;

	typedef enum logic [2:0] {
		OSU_ADD,
		OSU_SUB,
		OSU_AND,
		OSU_OR,
		OSU_XOR
	} osu_alu_e;

	typedef enum logic [1:0] {
		OSU_IDLE,
		OSU_SPILL,
		OSU_FILL
	} osu_st_e;

	typedef struct packed {
		osu_cmd_e                cmd;
		osu_alu_e                alu;
		logic [OSU_WORD_W-1:0]   data;
		logic [OSU_WORD_W-1:0]   data2;
	} osu_op_s;

	typedef struct packed {
		logic                    load;
		logic [OSU_DEPTH_W-1:0]  upper;
		logic [OSU_DEPTH_W-1:0]  lower;
	} osu_bnd_s;

	typedef struct packed {
		logic                    req;
		logic                    we;
		logic [OSU_ADDR_W-1:0]   addr;
		logic [OSU_WORD_W-1:0]   wdata;
	} osu_mem_s;

endpackage : osu_pkg

// ===== testbench/osu_mem_model.sv
`timescale 1ns/1ps
module osu_mem_model import osu_pkg::*; #(
	parameter int WORDS = 8
) (
	input  wire logic             clk_i,
	input  wire logic             srst_i,
	input  wire osu_mem_s         mem_i,
	output logic                  ack_o,
	output logic [OSU_WORD_W-1:0] rdata_o
);
	logic [OSU_WORD_W-1:0] mem [WORDS];
	int                    lag;
	// Random lag gives prompt and slow answers; read data only means something with ack
	always @(negedge clk_i) begin
		if (srst_i) begin
			ack_o   = 1'b0;
			rdata_o = '0;
			lag     = 0;
		end else if (mem_i.req && lag == 0) begin
			ack_o   = 1'b1;
			rdata_o = mem_i.we ? ~rdata_o : mem[mem_i.addr % WORDS];
			lag     = $urandom % 3;
		end else begin
			ack_o   = 1'b0;
			rdata_o = ~rdata_o;
			if (lag > 0) lag--;
		end
	end
	always @(posedge clk_i) begin
		if (mem_i.req && ack_o && mem_i.we) mem[mem_i.addr % WORDS] <= mem_i.wdata;
	end
endmodule : osu_mem_model

// ===== testbench/tb_operand_stack_unit.sv
`timescale 1ns/1ps
module tb_operand_stack_unit import osu_pkg::*; ;
	localparam int MW = 8;
	logic        clk_i = 1'b0;
	logic        srst_i = 1'b1;
	logic        op_valid_i = 1'b0;
	logic        viol_clr_i = 1'b0;
	osu_op_s     op_i = '0;
	osu_bnd_s    bnd_i = '0;
	logic        op_ready_o;
	logic        result_valid_o;
	logic        viol_o;
	logic        mem_ack_i;
	osu_mem_s    mem_o;
	logic [31:0] top_o;
	logic [31:0] second_o;
	logic [31:0] third_o;
	logic [31:0] result_o;
	logic [31:0] mem_rdata_i;
	logic [31:0] t3;
	logic [15:0] depth_o;
	logic [31:0] stk[$];
	int          n_errors = 0;
	int          checks = 0;
	int          ub;
	int          lb;

	osu_operand_stack #(.MEM_BASE(0), .MEM_WORDS(MW)) i_osu_operand_stack (.clk_i, .srst_i, .op_valid_i,
		.op_i, .op_ready_o, .bnd_i, .viol_clr_i, .top_o, .second_o, .third_o, .result_o, .result_valid_o,
		.depth_o, .viol_o, .mem_o, .mem_ack_i, .mem_rdata_i);
	osu_mem_model #(.WORDS(MW)) i_osu_mem_model (.clk_i, .srst_i, .mem_i(mem_o), .ack_o(mem_ack_i),
		.rdata_o(mem_rdata_i));

	initial begin
		forever #20 clk_i = ~clk_i;
	end

	function automatic logic [31:0] alu_f(osu_alu_e a, logic [31:0] l, logic [31:0] r);
		case (a)
			OSU_ADD: return l + r;
			OSU_SUB: return l - r;
			OSU_AND: return l & r;
			OSU_OR:  return l | r;
			default: return l ^ r;
		endcase
	endfunction : alu_f

	task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk_w

	task automatic chk_b(input logic g, input logic e);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk_b

	task automatic end_test(input string s);
		$display("Test %s done, mismatches so far %0d", s, n_errors);
	endtask : end_test

	task automatic tally_and_finish;
		$display("Comparisons %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish

	// Bounded wait: a stuck memory link must not hang the run
	task automatic wait_idle;
		int n;
		n = 0;
		// One extra edge lets a pending spill or refill show on the request line first
		@(negedge clk_i);
		while ((op_ready_o !== 1'b1 || mem_o.req !== 1'b0) && n < 200) begin
			@(negedge clk_i);
			n++;
		end
		chk_b(n < 200, 1'b1);
	endtask : wait_idle

	task automatic set_bnd(input int u, input int l);
		bnd_i = '{1'b1, 16'(u), 16'(l)};
		@(negedge clk_i);
		bnd_i.load = 1'b0;
		ub = u;
		lb = l;
	endtask : set_bnd

	task automatic exec(input osu_cmd_e c, input osu_alu_e a, input logic [31:0] d, input logic [31:0] d2);
		int       need;
		int       grow;
		int       dep;
		logic     v;
		logic [31:0] t;
		logic [31:0] s;
		logic [31:0] r;
		wait_idle();
		op_i = '{c, a, d, d2};
		op_valid_i = 1'b1;
		@(negedge clk_i);
		op_valid_i = 1'b0;
		// Execution edge has passed here; the result strobe stands for this cycle only
		@(negedge clk_i);
		dep = stk.size();
		need = (c == OSU_POP) ? 1 : (c == OSU_POP2 || c == OSU_ARITH) ? 2 : 0;
		grow = (c == OSU_PUSH) ? 1 : (c == OSU_PUSH2) ? 2 : (c == OSU_POP2) ? -2 : (need > 0) ? -1 : 0;
		v = (grow != 0) && (dep < need || dep + grow < lb || dep + grow > ub);
		r = '0;
		if (!v) begin
			case (c)
				OSU_PUSH:  stk.push_front(d);
				OSU_PUSH2: begin
					stk.push_front(d2);
					stk.push_front(d);
				end
				OSU_POP:   r = stk.pop_front();
				OSU_POP2:  begin
					r = stk.pop_front();
					t = stk.pop_front();
				end
				OSU_ARITH: begin
					t = stk.pop_front();
					s = stk.pop_front();
					r = alu_f(a, s, t);
					stk.push_front(r);
				end
				default: ;
			endcase
		end
		chk_b(viol_o, v);
		chk_w(32'(depth_o), 32'(stk.size()));
		if (stk.size() > 0) chk_w(top_o, stk[0]);
		if (stk.size() > 1) chk_w(second_o, stk[1]);
		chk_b(result_valid_o, !v && need > 0);
		if (!v && need > 0) chk_w(result_o, r);
		if (c == OSU_LOAD3) chk_w(third_o, d);
		if (v) begin
			viol_clr_i = 1'b1;
			@(negedge clk_i);
			viol_clr_i = 1'b0;
			chk_b(viol_o, 1'b0);
		end
	endtask : exec

	initial begin
		void'($urandom(63));
		ub = 14 + MW;
		lb = 0;
		repeat (12) @(negedge clk_i);
		srst_i = 1'b0;
		@(negedge clk_i);
		chk_w(32'(depth_o), 32'h0000_0000);
		chk_b(op_ready_o, 1'b1);
		chk_b(mem_o.req, 1'b0);
		chk_b(viol_o, 1'b0);
		end_test("reset");
		exec(OSU_POP, OSU_ADD, '0, '0);
		exec(OSU_PUSH, OSU_ADD, 32'hffff_ffff, '0);
		exec(OSU_ARITH, OSU_ADD, '0, '0);
		exec(OSU_POP2, OSU_ADD, '0, '0);
		exec(OSU_POP, OSU_ADD, '0, '0);
		end_test("underflow");
		t3 = $urandom;
		exec(OSU_LOAD3, OSU_ADD, t3, '0);
		for (int i = 0; i < 14 + MW; i++) exec(OSU_PUSH, OSU_ADD, $urandom, '0);
		exec(OSU_PUSH, OSU_ADD, $urandom, '0);
		wait_idle();
		// Deepest words left first, so memory holds the oldest pushes in order
		for (int k = 0; k < MW; k++) chk_w(i_osu_mem_model.mem[k], stk[stk.size() - 1 - k]);
		chk_w(third_o, t3);
		while (stk.size() > 0) exec(OSU_POP, OSU_ADD, '0, '0);
		end_test("spill_refill");
		exec(OSU_PUSH2, OSU_ADD, $urandom, $urandom);
		exec(OSU_PUSH2, OSU_ADD, $urandom, $urandom);
		repeat (3) exec(OSU_POP2, OSU_ADD, '0, '0);
		end_test("double");
		for (int k = 0; k < 5; k++) begin
			exec(OSU_PUSH, OSU_ADD, $urandom, '0);
			exec(OSU_PUSH, OSU_ADD, $urandom, '0);
			exec(OSU_ARITH, osu_alu_e'(k), '0, '0);
			exec(OSU_POP, OSU_ADD, '0, '0);
		end
		end_test("arith");
		set_bnd(3, 1);
		// Depth is below the lower bound here, yet an operator that moves nothing must not trip it
		exec(OSU_NOP, OSU_ADD, $urandom, '0);
		repeat (4) exec(OSU_PUSH, OSU_ADD, $urandom, '0);
		repeat (3) exec(OSU_POP, OSU_ADD, '0, '0);
		set_bnd(14 + MW, 0);
		exec(OSU_POP, OSU_ADD, '0, '0);
		end_test("bounds");
		repeat (300) exec(osu_cmd_e'(1 + $urandom % 5), osu_alu_e'($urandom % 5), $urandom, $urandom);
		end_test("random");
		tally_and_finish();
	end

	initial begin
		#(40 * 40000);
		n_errors++;
		$display("[FAIL] t=%0t timeout got %h exp %h", $time, 1'b0, 1'b1);
		tally_and_finish();
	end
endmodule : tb_operand_stack_unit
